// ### logic/gpp_pkg.sv
package gpp_pkg;

   // Register byte offsets
   localparam logic [7:0] GPP_DIR_OFF    = 8'h00;
   localparam logic [7:0] GPP_DATA_OFF   = 8'h04;
   localparam logic [7:0] GPP_IRQ_A_OFF  = 8'h08;
   localparam logic [7:0] GPP_IRQ_B_OFF  = 8'h0c;
   localparam logic [7:0] GPP_STAT_OFF   = 8'h10;

   // Direction register fields
   localparam int GPP_LOWDIR_BIT = 16;
   localparam int GPP_MEDDIR_BIT = 17;
   localparam logic [31:0] GPP_DIR_MASK = 32'h0003ffff;

   // Data register byte fields for the upper half
   localparam int GPP_LOWDAT_LSB = 16;
   localparam int GPP_MEDDAT_LSB = 24;

   // Interrupt config byte fields (four per register)
   localparam int GPP_IRQ_SEL_MSB = 4;
   localparam int GPP_IRQ_POL_BIT = 6;
   localparam int GPP_IRQ_EN_BIT  = 7;

   // Lower pin assignments of alternate functions
   localparam int GPP_S1_TX  = 15;
   localparam int GPP_S1_RX  = 14;
   localparam int GPP_S1_RTS = 13;
   localparam int GPP_S1_CTS = 12;
   localparam int GPP_S2_TX  = 11;
   localparam int GPP_S2_RX  = 10;
   localparam int GPP_S2_RTS = 9;
   localparam int GPP_S2_CTS = 8;
   localparam int GPP_TICK   = 3;

   // Reset values
   localparam logic [31:0] GPP_DIR_RST  = 32'h00000000;
   localparam logic [31:0] GPP_DATA_RST = 32'h00000000;
   localparam logic [31:0] GPP_IRQ_RST  = 32'h00000000;

   // Edges after reset release before the straps are caught
   localparam logic [2:0] GPP_STRAP_SETTLE = 3'h5;

endpackage : gpp_pkg

// ### logic/gpp_port.sv
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
module gpp_port
   import gpp_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [15:0] gpio_in,
   output logic      [15:0] gpio_out,
   output logic      [15:0] gpio_oe,
   input  wire logic [15:0] mem_d_in,
   output logic      [15:0] mem_d_out,
   output logic      [15:0] mem_d_oe,
   input  wire logic        rom_bus8,
   input  wire logic        sram_bus8,
   input  wire logic        io_bus8,
   input  wire logic        sdram_en,
   input  wire logic        serial1_tx_en,
   input  wire logic        serial1_rx_en,
   input  wire logic        serial1_flow_en,
   input  wire logic        serial1_ext_clk,
   input  wire logic        serial2_tx_en,
   input  wire logic        serial2_rx_en,
   input  wire logic        serial2_flow_en,
   input  wire logic        serial2_ext_clk,
   input  wire logic        serial1_tx,
   input  wire logic        serial1_req_send,
   input  wire logic        serial2_tx,
   input  wire logic        serial2_req_send,
   output logic             serial1_rx,
   output logic             serial1_clr_send,
   output logic             serial2_rx,
   output logic             serial2_clr_send,
   output logic             alt_serial_tick,
   output logic             serial1_ext_tick,
   output logic             serial2_ext_tick,
   output logic             boot_ecc_en,
   output logic      [1:0]  boot_width,
   output logic      [7:0]  ext_irq,
   output logic      [7:0]  ru_pin_level
);

   // Change accepted once stages two and three agree
   function automatic logic [15:0] agree(input logic [15:0] s2,
                                         input logic [15:0] s3,
                                         input logic [15:0] cur);
      agree = (s2 & s3) | (cur & (s2 | s3));
   endfunction : agree

   // One interrupt line from a config byte and the 32 port levels
   function automatic logic irq_line(input logic [7:0]  cfg,
                                     input logic [31:0] lvl);
      logic [4:0] sel;
      sel      = cfg[GPP_IRQ_SEL_MSB:0];
      irq_line = cfg[GPP_IRQ_EN_BIT] & (lvl[sel] ^ cfg[GPP_IRQ_POL_BIT]);
   endfunction : irq_line

   logic [31:0] port_direction_q;
   logic [31:0] port_data_q;
   logic [31:0] pin_irq_cfg_a_q;
   logic [31:0] pin_irq_cfg_b_q;
   logic [15:0] gp_s1_q;
   logic [15:0] gp_s2_q;
   logic [15:0] gp_s3_q;
   logic [15:0] gp_filt_q;
   logic [15:0] md_s1_q;
   logic [15:0] md_s2_q;
   logic [15:0] md_s3_q;
   logic [15:0] md_filt_q;
   logic [2:0]  strap_cnt_q;
   logic        strap_done_q;
   logic        boot_ecc_q;
   logic [1:0]  boot_width_q;
   logic        tick_prev_q;
   logic        tick_q;
   logic [31:0] prdata_q;
   logic [15:0] gpio_out_q;
   logic [15:0] gpio_oe_q;
   logic [15:0] mem_d_out_q;
   logic [15:0] mem_d_oe_q;
   logic        s1_rx_q;
   logic        s1_cts_q;
   logic        s2_rx_q;
   logic        s2_cts_q;
   logic [7:0]  ext_irq_q;
   logic [7:0]  ru_pin_q;
   logic        upper_ok;
   logic        wr_en;
   logic        rd_setup;
   logic        addr_hit;
   logic [15:0] low_dir;
   logic [15:0] up_dir;
   logic [31:0] port_lvl;
   logic [31:0] rd_mux;
   logic [15:0] pin_drv;
   logic [15:0] pin_en;

   // APB decode, zero wait states
   assign wr_en    = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   always_comb begin
      if (paddr == GPP_DIR_OFF) begin
         addr_hit = 1'b1;
      end else if (paddr == GPP_DATA_OFF) begin
         addr_hit = 1'b1;
      end else if (paddr == GPP_IRQ_A_OFF) begin
         addr_hit = 1'b1;
      end else if (paddr == GPP_IRQ_B_OFF) begin
         addr_hit = 1'b1;
      end else if (paddr == GPP_STAT_OFF) begin
         addr_hit = 1'b1;
      end else begin
         addr_hit = 1'b0;
      end
   end
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_hit;

   assign upper_ok = rom_bus8 & sram_bus8 & io_bus8 & ~sdram_en;

   // Per-bit direction of the lower 16 pins, per-byte direction of the upper 16 pins
   assign low_dir  = port_direction_q[15:0];
   assign up_dir   = {{8{port_direction_q[GPP_MEDDIR_BIT]}},
                      {8{port_direction_q[GPP_LOWDIR_BIT]}}};
   assign port_lvl = {md_filt_q, gp_filt_q};

   // Three-stage synchronisers on all port pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gp_s1_q   <= 16'h0000;
         gp_s2_q   <= 16'h0000;
         gp_s3_q   <= 16'h0000;
         gp_filt_q <= 16'h0000;
         md_s1_q   <= 16'h0000;
         md_s2_q   <= 16'h0000;
         md_s3_q   <= 16'h0000;
         md_filt_q <= 16'h0000;
      end else begin
         gp_s1_q   <= gpio_in;
         gp_s2_q   <= gp_s1_q;
         gp_s3_q   <= gp_s2_q;
         gp_filt_q <= agree(gp_s2_q, gp_s3_q, gp_filt_q);
         md_s1_q   <= mem_d_in;
         md_s2_q   <= md_s1_q;
         md_s3_q   <= md_s2_q;
         md_filt_q <= agree(md_s2_q, md_s3_q, md_filt_q);
      end
   end

   // Direction register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_direction_q <= GPP_DIR_RST;
      end else if (wr_en && paddr == GPP_DIR_OFF) begin
         port_direction_q <= pwdata & GPP_DIR_MASK;
      end
   end

   // Data register: inputs track pins, outputs hold written value; the upper half holds unless upper_ok
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_data_q <= GPP_DATA_RST;
      end else begin
         for (int i = 0; i < 16; i++) begin
            if (!low_dir[i]) begin
               port_data_q[i] <= gp_filt_q[i];
            end else if (wr_en && paddr == GPP_DATA_OFF) begin
               port_data_q[i] <= pwdata[i];
            end
         end
         for (int i = 0; i < 16; i++) begin
            if (!upper_ok) begin
               port_data_q[GPP_LOWDAT_LSB+i] <= port_data_q[GPP_LOWDAT_LSB+i];
            end else if (!up_dir[i]) begin
               port_data_q[GPP_LOWDAT_LSB+i] <= md_filt_q[i];
            end else if (wr_en && paddr == GPP_DATA_OFF) begin
               port_data_q[GPP_LOWDAT_LSB+i] <= pwdata[GPP_LOWDAT_LSB+i];
            end
         end
      end
   end

   // Interrupt pin selection registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_irq_cfg_a_q <= GPP_IRQ_RST;
         pin_irq_cfg_b_q <= GPP_IRQ_RST;
      end else if (wr_en && paddr == GPP_IRQ_A_OFF) begin
         pin_irq_cfg_a_q <= pwdata;
      end else if (wr_en && paddr == GPP_IRQ_B_OFF) begin
         pin_irq_cfg_b_q <= pwdata;
      end
   end

   // External interrupt lines from any port pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_irq_q <= 8'h00;
      end else begin
         for (int k = 0; k < 4; k++) begin
            ext_irq_q[k]   <= irq_line(pin_irq_cfg_a_q[8*k +: 8], port_lvl);
            ext_irq_q[k+4] <= irq_line(pin_irq_cfg_b_q[8*k +: 8], port_lvl);
         end
      end
   end

   // Boot straps caught once the synchroniser has settled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_cnt_q  <= 3'h0;
         strap_done_q <= 1'b0;
         boot_ecc_q   <= 1'b0;
         boot_width_q <= 2'h0;
      end else if (!strap_done_q) begin
         if (strap_cnt_q == GPP_STRAP_SETTLE) begin
            strap_done_q <= 1'b1;
            boot_ecc_q   <= gp_filt_q[2];
            boot_width_q <= gp_filt_q[1:0];
         end else begin
            strap_cnt_q <= strap_cnt_q + 3'h1;
         end
      end
   end

   // Alternate serial tick: one pulse per rising edge on pin 3 while it is an input
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_prev_q <= 1'b0;
         tick_q      <= 1'b0;
      end else begin
         tick_prev_q <= gp_filt_q[GPP_TICK];
         tick_q      <= ~low_dir[GPP_TICK] & gp_filt_q[GPP_TICK] & ~tick_prev_q;
      end
   end
   assign alt_serial_tick  = tick_q;
   assign serial1_ext_tick = tick_q & serial1_ext_clk;
   assign serial2_ext_tick = tick_q & serial2_ext_clk;

   // Lower pin drive with serial output overrides
   always_comb begin
      pin_drv = port_data_q[15:0];
      pin_en  = low_dir;
      if (low_dir[GPP_S1_TX] && serial1_tx_en) begin
         pin_drv[GPP_S1_TX] = serial1_tx;
      end
      if (low_dir[GPP_S1_RTS] && serial1_rx_en && serial1_flow_en) begin
         pin_drv[GPP_S1_RTS] = serial1_req_send;
      end
      if (low_dir[GPP_S2_TX] && serial2_tx_en) begin
         pin_drv[GPP_S2_TX] = serial2_tx;
      end
      if (low_dir[GPP_S2_RTS] && serial2_rx_en && serial2_flow_en) begin
         pin_drv[GPP_S2_RTS] = serial2_req_send;
      end
   end

   // Registered pin outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gpio_out_q  <= 16'h0000;
         gpio_oe_q   <= 16'h0000;
         mem_d_out_q <= 16'h0000;
         mem_d_oe_q  <= 16'h0000;
      end else begin
         gpio_out_q  <= pin_drv;
         gpio_oe_q   <= pin_en;
         mem_d_out_q <= port_data_q[31:16];
         mem_d_oe_q  <= up_dir & {16{upper_ok}};
      end
   end

   // Serial inputs, idle level when the function is off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_rx_q  <= 1'b1;
         s1_cts_q <= 1'b0;
         s2_rx_q  <= 1'b1;
         s2_cts_q <= 1'b0;
      end else begin
         s1_rx_q  <= (~low_dir[GPP_S1_RX] & serial1_rx_en) ? gp_filt_q[GPP_S1_RX] : 1'b1;
         s1_cts_q <= ~low_dir[GPP_S1_CTS] & serial1_tx_en & serial1_flow_en
                     & gp_filt_q[GPP_S1_CTS];
         s2_rx_q  <= (~low_dir[GPP_S2_RX] & serial2_rx_en) ? gp_filt_q[GPP_S2_RX] : 1'b1;
         s2_cts_q <= ~low_dir[GPP_S2_CTS] & serial2_tx_en & serial2_flow_en
                     & gp_filt_q[GPP_S2_CTS];
      end
   end

   // Level of shared pins 0..7 handed to the reconfigurable unit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ru_pin_q <= 8'h00;
      end else begin
         ru_pin_q <= gp_filt_q[7:0];
      end
   end

   // Read data captured in the setup phase
   always_comb begin
      if (paddr == GPP_DIR_OFF) begin
         rd_mux = port_direction_q;
      end else if (paddr == GPP_DATA_OFF) begin
         rd_mux = port_data_q;
      end else if (paddr == GPP_IRQ_A_OFF) begin
         rd_mux = pin_irq_cfg_a_q;
      end else if (paddr == GPP_IRQ_B_OFF) begin
         rd_mux = pin_irq_cfg_b_q;
      end else if (paddr == GPP_STAT_OFF) begin
         rd_mux = {16'h0000,
                   serial2_ext_clk, serial2_flow_en, serial2_rx_en, serial2_tx_en,
                   serial1_ext_clk, serial1_flow_en, serial1_rx_en, serial1_tx_en,
                   strap_done_q, boot_ecc_q, boot_width_q,
                   sdram_en, upper_ok, 2'h0};
      end else begin
         rd_mux = 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
      end else if (rd_setup) begin
         prdata_q <= rd_mux;
      end
   end

   assign prdata           = prdata_q;
   assign gpio_out         = gpio_out_q;
   assign gpio_oe          = gpio_oe_q;
   assign mem_d_out        = mem_d_out_q;
   assign mem_d_oe         = mem_d_oe_q;
   assign serial1_rx       = s1_rx_q;
   assign serial1_clr_send = s1_cts_q;
   assign serial2_rx       = s2_rx_q;
   assign serial2_clr_send = s2_cts_q;
   assign boot_ecc_en      = boot_ecc_q;
   assign boot_width       = boot_width_q;
   assign ext_irq          = ext_irq_q;
   assign ru_pin_level     = ru_pin_q;

endmodule : gpp_port

// ### bench/gpp_port_assertions.sv
`timescale 1ns/10ps
module gpp_port_assertions
   import gpp_pkg::*;
(
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [7:0]  paddr,
   input logic [31:0] pwdata,
   input logic [15:0] gpio_out,
   input logic [15:0] gpio_oe,
   input logic [15:0] mem_d_oe,
   input logic        rom_bus8,
   input logic        sram_bus8,
   input logic        io_bus8,
   input logic        sdram_en,
   input logic        serial1_tx_en,
   input logic        serial1_rx_en,
   input logic        serial1_flow_en,
   input logic        serial1_ext_clk,
   input logic        serial1_tx,
   input logic        serial1_rx,
   input logic        serial1_clr_send,
   input logic        alt_serial_tick,
   input logic        serial1_ext_tick
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic upper_ok;
   assign upper_ok = rom_bus8 & sram_bus8 & io_bus8 & ~sdram_en;
   sequence wr_at(logic [7:0] a);
      psel && penable && pwrite && paddr == a;
   endsequence
   sequence tx_live;
      serial1_tx_en && gpio_oe[15] ##1 gpio_oe[15];
   endsequence
   AST_DIR_OE: assert property (wr_at(GPP_DIR_OFF) |=> ##1 gpio_oe == $past(pwdata[15:0], 2))
      else $error("pin enables differ from direction written");
   AST_OUT_DAT: assert property (wr_at(GPP_DATA_OFF) |=> ##1
      ((gpio_out[7:0] ^ $past(pwdata[7:0], 2)) & gpio_oe[7:0]) == 8'h00)
      else $error("driven pins differ from data written");
   AST_UPPER_OE: assert property (wr_at(GPP_DIR_OFF) ##1 upper_ok |=>
      mem_d_oe == {{8{$past(pwdata[17], 2)}}, {8{$past(pwdata[16], 2)}}})
      else $error("upper byte enables wrong");
   AST_UPPER_OFF: assert property (!upper_ok |=> mem_d_oe == 16'h0000)
      else $error("upper half driven while unusable");
   AST_RESET_IN: assert property ($rose(presetn) |-> gpio_oe == 16'h0000 && mem_d_oe == 16'h0000)
      else $error("pin driven right after reset");
   AST_TX15: assert property (tx_live |-> gpio_out[15] == $past(serial1_tx))
      else $error("transmit data missing on its pin");
   AST_RX_OFF: assert property (!serial1_rx_en |=> serial1_rx)
      else $error("receive line not idle");
   AST_CTS_OFF: assert property (!serial1_flow_en |=> !serial1_clr_send)
      else $error("clear to send without flow control");
   AST_TICK: assert property (alt_serial_tick |=> !alt_serial_tick)
      else $error("tick longer than one cycle");
   AST_EXT_TICK: assert property (serial1_ext_tick |-> alt_serial_tick && serial1_ext_clk)
      else $error("serial tick without external clock");
endmodule : gpp_port_assertions

// ### bench/gpp_pins.sv
`timescale 1ns/10ps
module gpp_pins (
   input  logic [15:0] gpio_out,
   input  logic [15:0] gpio_oe,
   input  logic [15:0] mem_d_out,
   input  logic [15:0] mem_d_oe,
   input  logic [15:0] ext_g,
   input  logic [15:0] ext_m,
   output logic [15:0] gpio_in,
   output logic [15:0] mem_d_in
);
   // Outside devices let go of every line the port drives
   assign gpio_in  = (gpio_oe & gpio_out) | (~gpio_oe & ext_g);
   assign mem_d_in = (mem_d_oe & mem_d_out) | (~mem_d_oe & ext_m);
endmodule : gpp_pins

// ### bench/gpp_port_test.sv
`timescale 1ns/10ps
module gpp_port_test
   import gpp_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pready, pslverr, tick, ecc;
   logic        rom8, sram8, io8, sdram;
   logic [7:0]  paddr, irq, ru;
   logic [31:0] pwdata, prdata, d, w, mk;
   logic [1:0]  ten, ren, fen, xclk, s_tx, s_rts, s_rx, s_cts, s_xt, bw;
   logic [15:0] g_out, g_oe, g_in, m_out, m_oe, m_in, ext_g, ext_m;
   logic [32:0] exp_q[$];
   int          n_errors, comparisons, cyc, nt, nx1, nx2;
   always #50 pclk = ~pclk;
   gpp_port u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .gpio_in(g_in), .gpio_out(g_out), .gpio_oe(g_oe), .mem_d_in(m_in), .mem_d_out(m_out), .mem_d_oe(m_oe),
      .rom_bus8(rom8), .sram_bus8(sram8), .io_bus8(io8), .sdram_en(sdram),
      .serial1_tx_en(ten[0]), .serial1_rx_en(ren[0]), .serial1_flow_en(fen[0]), .serial1_ext_clk(xclk[0]),
      .serial2_tx_en(ten[1]), .serial2_rx_en(ren[1]), .serial2_flow_en(fen[1]), .serial2_ext_clk(xclk[1]),
      .serial1_tx(s_tx[0]), .serial1_req_send(s_rts[0]), .serial2_tx(s_tx[1]), .serial2_req_send(s_rts[1]),
      .serial1_rx(s_rx[0]), .serial1_clr_send(s_cts[0]), .serial2_rx(s_rx[1]), .serial2_clr_send(s_cts[1]),
      .alt_serial_tick(tick), .serial1_ext_tick(s_xt[0]), .serial2_ext_tick(s_xt[1]),
      .boot_ecc_en(ecc), .boot_width(bw), .ext_irq(irq), .ru_pin_level(ru));
   gpp_pins u_pins (.gpio_out(g_out), .gpio_oe(g_oe), .mem_d_out(m_out), .mem_d_oe(m_oe),
      .ext_g(ext_g), .ext_m(ext_m), .gpio_in(g_in), .mem_d_in(m_in));
   task test_done();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   task chk_rd(input logic [32:0] got, input logic [32:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: read %h expected %h", $time, got, exp);
      end
   endtask : chk_rd
   task chk_pin(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: output %h expected %h", $time, got, exp);
      end
   endtask : chk_pin
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h00000000);
   endtask : rd
   function automatic logic [31:0] port_val(input logic [31:0] m, input logic [31:0] wd);
      return (m & wd) | (~m & {ext_m, ext_g});
   endfunction : port_val
   always @(posedge pclk) begin
      if ((psel & penable & pready & ~pwrite) === 1'b1) begin
         chk_rd({pslverr, prdata}, exp_q.pop_front());
      end
      if (tick === 1'b1) nt++;
      if (s_xt[0] === 1'b1) nx1++;
      if (s_xt[1] === 1'b1) nx2++;
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         test_done();
      end
   end
   initial begin
      void'($urandom(46333));
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {ten, ren, fen, xclk, s_tx, s_rts} = '0;
      {rom8, sram8, io8, sdram} = 4'b1110;
      ext_g = 16'h0006;
      ext_m = 16'h0000;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (10) @(posedge pclk);
      chk_pin({ecc, bw}, 32'h00000006);
      rd(GPP_DIR_OFF, 33'h000000000);
      rd(GPP_STAT_OFF, {1'b0, 32'h000000e4});
      for (int i = 0; i < 4; i++) begin
         d = $urandom() & GPP_DIR_MASK;
         w = $urandom();
         {ext_m, ext_g} <= $urandom();
         mk = {{8{d[17]}}, {8{d[16]}}, d[15:0]};
         apb(1'b1, GPP_DIR_OFF, d);
         apb(1'b1, GPP_DATA_OFF, w);
         repeat (8) @(posedge pclk);
         rd(GPP_DIR_OFF, {1'b0, d});
         rd(GPP_DATA_OFF, {1'b0, port_val(mk, w)});
         chk_pin({m_oe, g_oe}, mk);
         chk_pin({m_out, g_out} & mk, w & mk);
      end
      apb(1'b1, GPP_DIR_OFF, 32'h00030000);
      for (int k = 0; k < 4; k++) begin
         {rom8, sram8, io8, sdram} <= 4'b1110 ^ (4'b0001 << k);
         repeat (3) @(posedge pclk);
         chk_pin(m_oe, 32'h00000000);
      end
      {rom8, sram8, io8, sdram} <= 4'b1110;
      repeat (3) @(posedge pclk);
      chk_pin(m_oe, 32'h0000ffff);
      rd(8'h14, {1'b1, 32'h00000000});
      apb(1'b1, GPP_DIR_OFF, 32'h0000aa00);
      ext_g <= 16'h1100;
      {ten, ren, fen} <= 6'h3f;
      {s_tx, s_rts} <= 4'($urandom());
      repeat (8) @(posedge pclk);
      chk_pin(s_rx, 32'h00000000);
      chk_pin(s_cts, 32'h00000003);
      chk_pin({g_out[15], g_out[13], g_out[11], g_out[9]}, {s_tx[0], s_rts[0], s_tx[1], s_rts[1]});
      {ren, fen} <= 4'h0;
      repeat (8) @(posedge pclk);
      chk_pin({s_rx, s_cts}, 32'h0000000c);
      apb(1'b1, GPP_DIR_OFF, 32'h00000000);
      xclk <= 2'b01;
      nt = 0;
      nx1 = 0;
      nx2 = 0;
      for (int t = 0; t < 5; t++) begin
         ext_g[3] <= 1'b1;
         repeat (4) @(posedge pclk);
         ext_g[3] <= 1'b0;
         repeat (4) @(posedge pclk);
      end
      repeat (6) @(posedge pclk);
      chk_pin(nt, 32'h00000005);
      chk_pin(nx1, 32'h00000005);
      chk_pin(nx2, 32'h00000000);
      apb(1'b1, GPP_IRQ_A_OFF, 32'h0000c585);
      apb(1'b1, GPP_IRQ_B_OFF, 32'h00000093);
      ext_g[5] <= 1'b1;
      ext_m <= 16'h0008;
      repeat (8) @(posedge pclk);
      chk_pin(irq, 32'h00000011);
      chk_pin(ru, ext_g[7:0]);
      rd(GPP_IRQ_A_OFF, {1'b0, 32'h0000c585});
      rd(GPP_IRQ_B_OFF, {1'b0, 32'h00000093});
      test_done();
   end
endmodule : gpp_port_test
bind gpp_port gpp_port_assertions u_ast (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .gpio_out, .gpio_oe, .mem_d_oe, .rom_bus8, .sram_bus8, .io_bus8, .sdram_en, .serial1_tx_en,
   .serial1_rx_en, .serial1_flow_en, .serial1_ext_clk, .serial1_tx, .serial1_rx, .serial1_clr_send,
   .alt_serial_tick, .serial1_ext_tick);
